// file: verilog/ccss_defines.vh
// Timing constants, clock divider and counter width for the card contact session sequencer.
`ifndef CCSS_DEFINES_VH
`define CCSS_DEFINES_VH
`define CCSS_SYS_HZ 25000000
`define CCSS_RX_MODE_CYC 200
`define CCSS_RST_LOW_MIN_CYC 40000
`define CCSS_RST_LOW_MAX_CYC 45000
`define CCSS_RST_LOW_CYC 42000
`define CCSS_WIN_OPEN_CYC 380
`define CCSS_WIN_CLOSE_CYC 42000
`define CCSS_NOANS_CYC 42001
`define CCSS_MARGIN_MS 50
`define CCSS_DEACT_MS 8'h64
`define CCSS_MS_CYC (`CCSS_SYS_HZ / 1000)
`define CCSS_CLK_DIV 3
`define CCSS_CNT_W 17
`endif

// file: verilog/ccss_ms_timer.v
// Millisecond time base and countdown used for the no-answer margin and the deactivation time limit.
`timescale 1ns/1ns
`default_nettype none
`include "ccss_defines.vh"
module ccss_ms_timer #(
  parameter MS_CYC = `CCSS_MS_CYC
) (
  input wire clock,
  input wire rst,
  input wire start,
  input wire [7:0] ms_count,
  output reg expired_r
);
  reg [15:0] tick_r;
  reg [7:0] left_r;
  reg run_r;
  // Counts whole milliseconds down from the loaded figure while running.
  always @(posedge clock) begin
    if (rst || start) begin
      tick_r <= 16'h0000;
      left_r <= ms_count;
      run_r <= start;
      expired_r <= 1'b0;
    end else if (run_r) begin
      if (tick_r == MS_CYC - 1) begin
        tick_r <= 16'h0000;
        if (left_r == 8'h01) begin
          run_r <= 1'b0;
          expired_r <= 1'b1;
        end
        left_r <= left_r - 8'h01;
      end else begin
        tick_r <= tick_r + 16'h0001;
      end
    end else begin
      expired_r <= 1'b0;
    end
  end
endmodule // ccss_ms_timer
`default_nettype wire

// file: verilog/ccss_sequencer.v
// Contact activation, cold and warm reset, answer window and deactivation sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "ccss_defines.vh"
module ccss_sequencer #(
  parameter RST_LOW_CYC = `CCSS_RST_LOW_CYC,
  parameter WIN_CLOSE_CYC = `CCSS_WIN_CLOSE_CYC,
  parameter NOANS_CYC = `CCSS_NOANS_CYC,
  parameter MS_CYC = `CCSS_MS_CYC
) (
  input wire clock,
  input wire rst,
  input wire card_present,
  input wire supply_stable,
  input wire supply_low,
  input wire power_fail,
  input wire session_end,
  input wire answer_bad,
  input wire card_io_in,
  input wire tx_active,
  input wire tx_bit,
  output reg card_supply_en_r,
  output reg card_clk_r,
  output reg card_rst_r,
  output reg card_io_out_r,
  output reg card_io_oe_r,
  output reg answer_window_r,
  output reg session_ready_r,
  output reg no_answer_r,
  output reg warm_req_r,
  output reg deact_done_r
);
  localparam S_IDLE = 9'h001;
  localparam S_POWER = 9'h002;
  localparam S_COLD = 9'h004;
  localparam S_WAIT = 9'h008;
  localparam S_SESS = 9'h010;
  localparam S_WARM = 9'h020;
  localparam S_MARGIN = 9'h040;
  localparam S_DRST = 9'h080;
  localparam S_DOFF = 9'h100;

  reg [8:0] state_r;
  reg [8:0] state_nxt;
  reg [2:0] pres_s_r;
  reg [2:0] stab_s_r;
  reg [2:0] low_s_r;
  reg [2:0] io_s_r;
  reg [1:0] div_r;
  reg [`CCSS_CNT_W-1:0] cyc_r;
  reg warm_done_r;
  reg got_answer_r;
  reg io_prev_r;
  reg tmr_start;
  reg [7:0] tmr_ms;
  wire tmr_exp;
  wire card_edge;
  wire io_fall;
  wire pres;
  wire abort;

  // Two-flop synchronisers for pin inputs; only stage 1 is read.
  always @(posedge clock) begin
    if (rst) begin
      pres_s_r <= 3'h0;
      stab_s_r <= 3'h0;
      low_s_r <= 3'h0;
      io_s_r <= 3'h7;
    end else begin
      pres_s_r <= {pres_s_r[1:0], card_present};
      stab_s_r <= {stab_s_r[1:0], supply_stable};
      low_s_r <= {low_s_r[1:0], supply_low};
      io_s_r <= {io_s_r[1:0], card_io_in};
    end
  end
  assign pres = pres_s_r[1];
  assign abort = !pres || power_fail || session_end;

  // Card clock divider: toggles every CLK_DIV+1 system cycles (25/8 MHz).
  always @(posedge clock) begin
    if (rst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign card_edge = (div_r == `CCSS_CLK_DIV) && card_clk_r;

  // Answer start detection on the synchronised data line.
  always @(posedge clock) begin
    if (rst) begin
      io_prev_r <= 1'b1;
    end else begin
      io_prev_r <= io_s_r[1];
    end
  end
  assign io_fall = io_prev_r && !io_s_r[1];

  ccss_ms_timer #(.MS_CYC(MS_CYC)) u_ms (
    .clock(clock),
    .rst(rst),
    .start(tmr_start),
    .ms_count(tmr_ms),
    .expired_r(tmr_exp)
  );

  // Next state and millisecond timer control.
  always @* begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_ms = 8'h00;
    case (state_r)
      S_IDLE: begin
        if (pres && !power_fail) begin
          state_nxt = S_POWER;
        end
      end
      S_POWER: begin
        if (abort) begin
          state_nxt = S_DRST;
        end else if (stab_s_r[1]) begin
          state_nxt = S_COLD;
        end
      end
      S_COLD, S_WARM: begin
        if (abort) begin
          state_nxt = S_DRST;
        end else if (card_edge && cyc_r == RST_LOW_CYC - 1) begin
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (abort) begin
          state_nxt = S_DRST;
        end else if (got_answer_r && answer_bad && !warm_done_r) begin
          state_nxt = S_WARM;
        end else if (got_answer_r && !answer_bad) begin
          state_nxt = S_SESS;
        end else if (!got_answer_r && card_edge && cyc_r == NOANS_CYC - 1) begin
          state_nxt = S_MARGIN;
          tmr_start = 1'b1;
          tmr_ms = 8'd1;
        end else if (got_answer_r && answer_bad) begin
          state_nxt = S_DRST;
        end
      end
      S_MARGIN: begin
        if (abort || tmr_exp) begin
          state_nxt = S_DRST;
        end
      end
      S_SESS: begin
        if (abort) begin
          state_nxt = S_DRST;
        end
      end
      S_DRST: begin
        state_nxt = S_DOFF;
        tmr_start = 1'b1;
        tmr_ms = `CCSS_DEACT_MS;
      end
      S_DOFF: begin
        if (low_s_r[1] || tmr_exp) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_DRST;
      end
    endcase
  end

  // State, card clock cycle counter and output registers.
  always @(posedge clock) begin
    if (rst) begin
      state_r <= S_IDLE;
      cyc_r <= {`CCSS_CNT_W{1'b0}};
      card_clk_r <= 1'b0;
      warm_done_r <= 1'b0;
      got_answer_r <= 1'b0;
      card_supply_en_r <= 1'b0;
      card_rst_r <= 1'b0;
      card_io_out_r <= 1'b0;
      card_io_oe_r <= 1'b1;
      answer_window_r <= 1'b0;
      session_ready_r <= 1'b0;
      no_answer_r <= 1'b0;
      warm_req_r <= 1'b0;
      deact_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      no_answer_r <= (state_r == S_WAIT) && (state_nxt == S_MARGIN);
      warm_req_r <= (state_r == S_WAIT) && (state_nxt == S_WARM);
      deact_done_r <= (state_r == S_DOFF) && (state_nxt == S_IDLE);
      if (state_nxt != state_r) begin
        cyc_r <= {`CCSS_CNT_W{1'b0}};
      end else if (card_edge) begin
        cyc_r <= cyc_r + 1'b1;
      end
      if (div_r == `CCSS_CLK_DIV) begin
        card_clk_r <= (state_r == S_IDLE || state_r == S_POWER || state_r == S_DOFF
          || state_nxt == S_DOFF) ? 1'b0 : !card_clk_r;
      end
      if (state_nxt == S_DOFF || state_nxt == S_IDLE) begin
        card_clk_r <= 1'b0;
      end
      // Supply drops one cycle after the clock and data line are already low.
      card_supply_en_r <= !(state_nxt == S_IDLE || state_r == S_DOFF);
      card_rst_r <= (state_nxt == S_WAIT || state_nxt == S_SESS || state_nxt == S_MARGIN)
        && state_r != S_DRST;
      if (state_nxt == S_COLD || state_nxt == S_WARM || state_nxt == S_WAIT
          || state_nxt == S_MARGIN) begin
        card_io_oe_r <= 1'b0;
      end else if (state_nxt == S_SESS) begin
        card_io_oe_r <= tx_active && !tx_bit;
      end else if (state_nxt == S_DRST) begin
        // Data line waits one cycle so that reset falls first.
        card_io_oe_r <= card_io_oe_r;
      end else begin
        card_io_oe_r <= 1'b1;
      end
      card_io_out_r <= 1'b0;
      answer_window_r <= (state_nxt == S_WAIT);
      session_ready_r <= (state_nxt == S_SESS);
      if (state_nxt == S_WARM) begin
        warm_done_r <= 1'b1;
      end else if (state_nxt == S_IDLE) begin
        warm_done_r <= 1'b0;
      end
      if (state_r == S_WAIT && io_fall) begin
        got_answer_r <= 1'b1;
      end else if (state_nxt != S_WAIT) begin
        got_answer_r <= 1'b0;
      end
    end
  end
endmodule // ccss_sequencer
`default_nettype wire

// file: tb/ccss_props.sv
// Checker of contact ordering and reset timing at the sequencer ports.
`timescale 1ns/1ns
`default_nettype none
module ccss_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic card_supply_en_r,
  input wire logic card_clk_r,
  input wire logic card_rst_r,
  input wire logic card_io_oe_r,
  input wire logic answer_window_r,
  input wire logic no_answer_r,
  input wire logic warm_req_r,
  input wire logic deact_done_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Release edge of the card reset, and the power drop that ends a session.
  sequence rel_s; $rose(card_rst_r); endsequence
  sequence drop_s; $fell(card_supply_en_r); endsequence
  chk_rst_unpowered: assert property (!card_supply_en_r |-> !card_rst_r)
    else $error("reset high without supply");
  chk_clk_unpowered: assert property (card_clk_r |-> card_supply_en_r)
    else $error("clock without supply");
  chk_io_unpowered: assert property (!card_supply_en_r |-> card_io_oe_r)
    else $error("data line not low without supply");
  chk_down_order: assert property (drop_s |-> !card_rst_r && !$past(card_rst_r))
    else $error("supply dropped before reset low");
  chk_off_last: assert property (drop_s |-> $past(card_io_oe_r) && !$past(card_clk_r))
    else $error("supply dropped before clock and data low");
  chk_win_opens: assert property (rel_s |-> answer_window_r)
    else $error("window closed at release");
  chk_win_needs_rst: assert property (answer_window_r |-> card_rst_r)
    else $error("window open while reset low");
  chk_low_hold: assert property (rel_s |-> !$past(card_rst_r, 8))
    else $error("reset low too short");
  chk_warm_keep: assert property (warm_req_r |-> ##[0:1] (!card_rst_r && card_supply_en_r))
    else $error("warm reset order wrong");
  chk_done_off: assert property (deact_done_r |-> !card_supply_en_r && !card_rst_r)
    else $error("done with contacts live");
  chk_events_apart: assert property ($onehot0({no_answer_r, warm_req_r, deact_done_r}))
    else $error("status events overlap");
endmodule // ccss_props
bind ccss_sequencer ccss_props chk (.clock(clock), .rst(rst),
  .card_supply_en_r(card_supply_en_r), .card_clk_r(card_clk_r), .card_rst_r(card_rst_r),
  .card_io_oe_r(card_io_oe_r), .answer_window_r(answer_window_r), .no_answer_r(no_answer_r),
  .warm_req_r(warm_req_r), .deact_done_r(deact_done_r));
`default_nettype wire

// file: tb/ccss_card_model.sv
// Behavioural chip card that answers a reset after a chosen delay.
`timescale 1ns/1ns
`default_nettype none
module ccss_card_model (
  input wire logic card_clk,
  input wire logic card_rst,
  input wire logic answer_on,
  input wire logic [7:0] ans_dly,
  output wire logic io_low
);
  logic [7:0] n;
  // Counts card clocks since release; reset is asynchronous and active low.
  always @(posedge card_clk or negedge card_rst) begin
    if (!card_rst) n <= 8'h00;
    else if (n != 8'hff) n <= n + 8'h01;
  end
  // Line released from clock start; a 12 clock start bit opens the answer.
  assign io_low = answer_on && card_rst && n >= ans_dly && n < ans_dly + 8'h0c;
endmodule // ccss_card_model
`default_nettype wire

// file: tb/test_card_contact_session_sequencer.sv
// Self-checking bench for the card contact session sequencer.
`timescale 1ns/1ns
`default_nettype none
module test_card_contact_session_sequencer;
  logic clock = 1'b0, rst = 1'b1, card_present = 1'b0, low_ok = 1'b1;
  logic supply_stable = 1'b0, supply_low = 1'b1, power_fail = 1'b0, session_end = 1'b0;
  logic answer_bad = 1'b0, tx_active = 1'b0, tx_bit = 1'b1, answer_on = 1'b0;
  logic [7:0] ans_dly = 8'h08;
  logic [31:0] seed = 32'h655e;
  wire logic card_low, card_io_in, sup_en, cclk, crst, io_out, io_oe, win, ready, noans, warm, done;
  int err_total = 0, cmp_count = 0, cc = 0, n, t0;
  ccss_sequencer #(.RST_LOW_CYC(50), .WIN_CLOSE_CYC(55), .NOANS_CYC(56), .MS_CYC(10)) uut (
    .clock(clock), .rst(rst), .card_present(card_present), .supply_stable(supply_stable),
    .supply_low(supply_low), .power_fail(power_fail), .session_end(session_end),
    .answer_bad(answer_bad), .card_io_in(card_io_in), .tx_active(tx_active), .tx_bit(tx_bit),
    .card_supply_en_r(sup_en), .card_clk_r(cclk), .card_rst_r(crst), .card_io_out_r(io_out),
    .card_io_oe_r(io_oe), .answer_window_r(win), .session_ready_r(ready),
    .no_answer_r(noans), .warm_req_r(warm), .deact_done_r(done));
  ccss_card_model card (.card_clk(cclk), .card_rst(crst), .answer_on(answer_on),
    .ans_dly(ans_dly), .io_low(card_low));
  // Pulled-up data line: low when either party drives it.
  assign card_io_in = (io_oe ? io_out : 1'b1) && !card_low;
  initial begin
    forever #20 clock = ~clock;
  end
  // Supply monitor model.
  always @(negedge clock) begin
    supply_stable <= sup_en;
    supply_low <= !sup_en && low_ok;
  end
  // Count of card clock rises, kept off the falling edge where it is read.
  always @(posedge cclk) begin
    cc++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Waits for release and checks the low time, as card clocks, against 48 to 53.
  task automatic release_wait;
    t0 = cc;
    for (n = 0; n < 3000 && crst !== 1'b1; n++) @(negedge clock);
    chk((cc - t0) inside {[48:53]}, 1);
    chk({win, io_oe}, 2'b10);
  endtask
  // One session: bad first answer, card answering, and how it is ended.
  task automatic session(input logic bad, input logic ans, input int stop);
    seed = xs(seed);
    ans_dly = 8'h04 + {4'h0, seed[3:0]};
    answer_on = ans;
    answer_bad = bad;
    card_present = 1'b1;
    release_wait();
    if (bad) begin
      for (n = 0; n < 600 && warm !== 1'b1; n++) @(negedge clock);
      chk(warm, 1);
      answer_bad = 1'b0;
      for (n = 0; n < 10 && crst !== 1'b0; n++) @(negedge clock);
      chk(sup_en, 1);
      release_wait();
    end
    if (ans) begin
      for (n = 0; n < 600 && ready !== 1'b1; n++) @(negedge clock);
      chk(ready, 1);
      t0 = cc;
      repeat (32) @(negedge clock);
      chk(cc - t0, 4);
      tx_bit = seed[4];
      tx_active = 1'b1;
      repeat (2) @(negedge clock);
      chk(io_oe, !tx_bit);
      tx_active = 1'b0;
      repeat (2) @(negedge clock);
      chk(io_oe, 0);
      low_ok = (stop != 1);
      if (stop == 0) session_end = 1'b1;
      if (stop == 1) power_fail = 1'b1;
      if (stop == 2) card_present = 1'b0;
      for (n = 0; n < 10 && crst !== 1'b0; n++) @(negedge clock);
      chk(sup_en, 1);
      @(negedge clock);
      chk({sup_en, cclk, io_oe}, 3'b101);
      @(negedge clock);
      chk({sup_en, cclk, io_oe}, 3'b001);
    end else begin
      t0 = cc;
      for (n = 0; n < 1200 && noans !== 1'b1; n++) @(negedge clock);
      chk({noans, (cc - t0) inside {[56:118]}}, 2'b11);
    end
    for (n = 0; n < 1100 && done !== 1'b1; n++) @(negedge clock);
    chk(done, 1);
    {card_present, session_end, power_fail, low_ok} = 4'h1;
    repeat (5) @(negedge clock);
  endtask
  initial begin
    #2000000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    chk({sup_en, crst, cclk, io_oe}, 4'h1);
    session(0, 1, 0);
    session(1, 1, 1);
    session(0, 0, 0);
    session(0, 1, 2);
    // A malformed answer after the warm reset as well ends the session.
    answer_on = 1'b1;
    answer_bad = 1'b1;
    card_present = 1'b1;
    release_wait();
    for (n = 0; n < 600 && warm !== 1'b1; n++) @(negedge clock);
    chk(warm, 1);
    release_wait();
    for (n = 0; n < 600 && sup_en !== 1'b0; n++) @(negedge clock);
    card_present = 1'b0;
    chk({sup_en, ready}, 2'b00);
    for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clock);
    chk(done, 1);
    answer_bad = 1'b0;
    wrap_up();
  end
endmodule // test_card_contact_session_sequencer
`default_nettype wire
